// [verilog/mtd_regs.svh]
// Purpose: register offsets, field positions and reset values of the threshold detector
// Assumes: byte-wide register port, 8-bit offsets
// Notes: definitions only
`ifndef MTD_REGS_SVH
`define MTD_REGS_SVH
`define MTD_OFF_CFG 8'h52
`define MTD_OFF_SRC 8'h53
`define MTD_OFF_XHI 8'h54
`define MTD_OFF_XLO 8'h55
`define MTD_OFF_YHI 8'h56
`define MTD_OFF_YLO 8'h57
`define MTD_OFF_ZHI 8'h58
`define MTD_OFF_ZLO 8'h59
`define MTD_RST_BYTE 8'h00
`define MTD_RD_UNMAPPED 8'h00
// configuration fields
`define MTD_CFG_LATCH 7
`define MTD_CFG_OR 6
`define MTD_CFG_ZEN 5
`define MTD_CFG_YEN 4
`define MTD_CFG_XEN 3
`define MTD_CFG_WAKE 2
`define MTD_CFG_IRQEN 1
`define MTD_CFG_PIN1 0
// source fields
`define MTD_SRC_EA 7
// top bit of the x high byte selects the debounce mode
`define MTD_XHI_DBCLR 7
`define MTD_THR_W 15
`define MTD_THR_HI_W 7
`define MTD_SAMPLE_W 16
`define MTD_OFFSET_W 15
`define MTD_CNT_W 8
`endif

// [verilog/mtd_pkg.sv]
// Purpose: shared types of the threshold detector
// Assumes: constants live in mtd_regs.svh
// Notes: nothing here is imported, use mtd_pkg::name
package mtd_pkg;
	typedef logic [7:0] mtd_byte_t;
	typedef logic [2:0] mtd_axes_t;
	// how enabled axes combine
	typedef enum logic {
		MTD_ALL_BELOW = 1'b0,
		MTD_ANY_ABOVE = 1'b1
	} mtd_comb_t;
endpackage

// [verilog/mtd_axis.sv]
// Purpose: one axis: offset correction, magnitude, threshold compare
// Assumes: offset is 15-bit two's complement in sample LSBs
// Notes: corrected value is held in a register, compares are combinational
`timescale 1ns/1ps
module mtd_axis #(
	parameter int SW = 16,
	parameter int OW = 15,
	parameter int TW = 15
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic load,
	input wire logic raw_mode,
	input wire logic [SW-1:0] sample,
	input wire logic [OW-1:0] offset,
	input wire logic [TW-1:0] threshold,
	output logic [SW-1:0] corrected,
	output logic at_or_above,
	output logic at_or_below,
	output logic negative
);
	logic [SW-1:0] corr_ff;
	logic [SW:0] diff;
	logic [SW-1:0] nxt_corr;
	logic [SW:0] mag;
	// subtract sign-extended offset, saturate so a wrap never fakes an event
	assign diff = {sample[SW-1], sample} - {{(SW+1-OW){offset[OW-1]}}, offset};
	assign nxt_corr = raw_mode ? sample :
		(diff[SW] != diff[SW-1]) ? {diff[SW], {(SW-1){~diff[SW]}}} : diff[SW-1:0];
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			corr_ff <= '0;
		end else if (load) begin
			corr_ff <= nxt_corr;
		end
	end
	assign corrected = corr_ff;
	// unsigned magnitude against unsigned threshold, sign kept apart
	assign negative = corr_ff[SW-1];
	assign mag = corr_ff[SW-1] ? ({1'b0, ~corr_ff} + 1'b1) : {1'b0, corr_ff};
	assign at_or_above = mag >= {{(SW+1-TW){1'b0}}, threshold};
	assign at_or_below = mag <= {{(SW+1-TW){1'b0}}, threshold};
endmodule

// [verilog/mtd_top.sv]
// Purpose: magnetic threshold event detector with byte register port
// Assumes: samples arrive as one-cycle strobes on clk_sys from the sensor core
// Notes:
// Contract
// - latch off: event flag follows detection output every debounce step
// - latch on: flag stays set until source register is read
// - select 0: event when all enabled magnitudes at or below threshold
// - select 1: event when any enabled magnitude at or above threshold
// - each axis has enable bit including or excluding it from detection
// - wake enable gates event flag into auto sleep/wake evaluation
// - interrupt output driven only when interrupt enable is set
// - routing bit 0 selects pin two, 1 pin one, OR'd with others
// - thresholds are unsigned 15 bits, upper 7 high byte, lower 8 low
// - raw mode off: compare against offset-corrected samples
// - debounce mode 1: counter cleared when condition false
// - debounce mode 0: counter decremented when condition false
// - event-active bit set when condition true or latched true
// - source reports per-axis event flag for X, Y and Z
// - per-axis polarity bit: 0 positive, 1 negative field
// - per-axis event and polarity read zero when axis disabled
// - debounce mode in top of X high byte; Y, Z tops read zero
// - flag set when counter reaches count; counter never exceeds it
// - one debounce step per sample; hybrid mode halves the rate
// - offset subtracted before samples reach output and detection
`timescale 1ns/1ps
`include "mtd_regs.svh"
module mtd_top #(
	parameter int SW = `MTD_SAMPLE_W,
	parameter int OW = `MTD_OFFSET_W,
	parameter int CW = `MTD_CNT_W
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [SW-1:0] sample_x,
	input wire logic [SW-1:0] sample_y,
	input wire logic [SW-1:0] sample_z,
	input wire logic [OW-1:0] offset_x,
	input wire logic [OW-1:0] offset_y,
	input wire logic [OW-1:0] offset_z,
	input wire logic raw_mode,
	input wire logic hybrid_mode,
	input wire logic [CW-1:0] debounce_count,
	input wire logic other_irq_one,
	input wire logic other_irq_two,
	output logic [SW-1:0] corr_x,
	output logic [SW-1:0] corr_y,
	output logic [SW-1:0] corr_z,
	output logic corr_valid,
	output logic event_active_flag,
	output logic wake_event,
	output logic irq_pin_one,
	output logic irq_pin_two
);
	// configuration and threshold storage
	mtd_pkg::mtd_byte_t cfg_ff;
	logic dbclr_ff;
	logic [`MTD_THR_HI_W-1:0] thr_xh_ff;
	logic [`MTD_THR_HI_W-1:0] thr_yh_ff;
	logic [`MTD_THR_HI_W-1:0] thr_zh_ff;
	mtd_pkg::mtd_byte_t thr_xl_ff;
	mtd_pkg::mtd_byte_t thr_yl_ff;
	mtd_pkg::mtd_byte_t thr_zl_ff;
	mtd_pkg::mtd_byte_t rdata_ff;
	// detection state
	logic half_ff;
	logic step_ff;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic ea_ff;
	logic nxt_ea;
	mtd_pkg::mtd_axes_t he_ff;
	mtd_pkg::mtd_axes_t hp_ff;
	mtd_pkg::mtd_axes_t nxt_he;
	mtd_pkg::mtd_axes_t nxt_hp;

	// decode
	wire wr_cfg = reg_wr && (reg_addr == `MTD_OFF_CFG);
	wire wr_xh = reg_wr && (reg_addr == `MTD_OFF_XHI);
	wire wr_xl = reg_wr && (reg_addr == `MTD_OFF_XLO);
	wire wr_yh = reg_wr && (reg_addr == `MTD_OFF_YHI);
	wire wr_yl = reg_wr && (reg_addr == `MTD_OFF_YLO);
	wire wr_zh = reg_wr && (reg_addr == `MTD_OFF_ZHI);
	wire wr_zl = reg_wr && (reg_addr == `MTD_OFF_ZLO);
	wire rd_src = reg_rd && (reg_addr == `MTD_OFF_SRC);

	// configuration fields
	wire latch_en = cfg_ff[`MTD_CFG_LATCH];
	wire comb_or = cfg_ff[`MTD_CFG_OR];
	wire wake_en = cfg_ff[`MTD_CFG_WAKE];
	wire irq_en = cfg_ff[`MTD_CFG_IRQEN];
	wire route_one = cfg_ff[`MTD_CFG_PIN1];
	wire [2:0] axis_en = {cfg_ff[`MTD_CFG_ZEN], cfg_ff[`MTD_CFG_YEN], cfg_ff[`MTD_CFG_XEN]};

	// thresholds: high byte upper 7 bits, low byte lower 8
	wire [`MTD_THR_W-1:0] thr_x = {thr_xh_ff, thr_xl_ff};
	wire [`MTD_THR_W-1:0] thr_y = {thr_yh_ff, thr_yl_ff};
	wire [`MTD_THR_W-1:0] thr_z = {thr_zh_ff, thr_zl_ff};

	// register writes; source register is read-only
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cfg_ff <= `MTD_RST_BYTE;
		end else if (wr_cfg) begin
			cfg_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dbclr_ff <= 1'b0;
			thr_xh_ff <= '0;
		end else if (wr_xh) begin
			dbclr_ff <= reg_wdata[`MTD_XHI_DBCLR];
			thr_xh_ff <= reg_wdata[`MTD_THR_HI_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			thr_yh_ff <= '0;
			thr_zh_ff <= '0;
		end else begin
			// top bit dropped on Y and Z, so it reads zero
			if (wr_yh) begin
				thr_yh_ff <= reg_wdata[`MTD_THR_HI_W-1:0];
			end
			if (wr_zh) begin
				thr_zh_ff <= reg_wdata[`MTD_THR_HI_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			thr_xl_ff <= `MTD_RST_BYTE;
			thr_yl_ff <= `MTD_RST_BYTE;
			thr_zl_ff <= `MTD_RST_BYTE;
		end else begin
			if (wr_xl) begin
				thr_xl_ff <= reg_wdata;
			end
			if (wr_yl) begin
				thr_yl_ff <= reg_wdata;
			end
			if (wr_zl) begin
				thr_zl_ff <= reg_wdata;
			end
		end
	end

	// hybrid mode uses every second sample as a debounce step
	wire take = sample_valid && (!hybrid_mode || half_ff);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			half_ff <= 1'b0;
			step_ff <= 1'b0;
		end else begin
			if (sample_valid) begin
				half_ff <= hybrid_mode ? ~half_ff : 1'b0;
			end
			step_ff <= take;
		end
	end

	// per-axis correction and compare
	mtd_pkg::mtd_axes_t ge;
	mtd_pkg::mtd_axes_t le;
	mtd_pkg::mtd_axes_t neg;

	mtd_axis #(.SW(SW), .OW(OW), .TW(`MTD_THR_W)) u_ax_x (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.load(sample_valid),
		.raw_mode(raw_mode),
		.sample(sample_x),
		.offset(offset_x),
		.threshold(thr_x),
		.corrected(corr_x),
		.at_or_above(ge[0]),
		.at_or_below(le[0]),
		.negative(neg[0])
	);

	mtd_axis #(.SW(SW), .OW(OW), .TW(`MTD_THR_W)) u_ax_y (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.load(sample_valid),
		.raw_mode(raw_mode),
		.sample(sample_y),
		.offset(offset_y),
		.threshold(thr_y),
		.corrected(corr_y),
		.at_or_above(ge[1]),
		.at_or_below(le[1]),
		.negative(neg[1])
	);

	mtd_axis #(.SW(SW), .OW(OW), .TW(`MTD_THR_W)) u_ax_z (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.load(sample_valid),
		.raw_mode(raw_mode),
		.sample(sample_z),
		.offset(offset_z),
		.threshold(thr_z),
		.corrected(corr_z),
		.at_or_above(ge[2]),
		.at_or_below(le[2]),
		.negative(neg[2])
	);

	// corrected data stands one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			corr_valid <= 1'b0;
		end else begin
			corr_valid <= sample_valid;
		end
	end

	// axis hits per mode; an empty axis set never detects
	wire [2:0] hit_or = axis_en & ge;
	wire [2:0] hit_and = axis_en & le;
	wire all_below = (axis_en != 3'h0) && ((le | ~axis_en) == 3'h7);
	wire any_above = hit_or != 3'h0;
	wire cond = comb_or ? any_above : all_below;
	wire [2:0] hit = comb_or ? hit_or : hit_and;

	// debounce: count up on true, clear or step down on false
	always_comb begin
		nxt_cnt = cnt_ff;
		if (cond) begin
			if (cnt_ff < debounce_count) begin
				nxt_cnt = cnt_ff + 1'b1;
			end else begin
				nxt_cnt = debounce_count;
			end
		end else if (dbclr_ff) begin
			nxt_cnt = '0;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	// detection output of this step
	wire det = cond && (nxt_cnt == debounce_count);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= '0;
		end else if (step_ff) begin
			cnt_ff <= nxt_cnt;
		end
	end

	// event and axis flags: tracking or latched, set beats read clear
	always_comb begin
		nxt_ea = ea_ff;
		nxt_he = he_ff;
		nxt_hp = hp_ff;
		if (latch_en) begin
			if (rd_src) begin
				nxt_ea = 1'b0;
				nxt_he = '0;
				nxt_hp = '0;
			end
			if (step_ff && det) begin
				nxt_ea = 1'b1;
				nxt_he = he_ff | hit;
				nxt_hp = (hp_ff & ~hit) | (hit & neg);
			end
		end else if (step_ff) begin
			nxt_ea = det;
			nxt_he = det ? hit : 3'h0;
			nxt_hp = det ? (hit & neg) : 3'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ea_ff <= 1'b0;
			he_ff <= '0;
			hp_ff <= '0;
		end else begin
			ea_ff <= nxt_ea;
			he_ff <= nxt_he;
			hp_ff <= nxt_hp;
		end
	end

	// source byte: disabled axes always read zero
	wire [2:0] he_vis = he_ff & axis_en;
	wire [2:0] hp_vis = hp_ff & axis_en;
	wire [7:0] src_byte = {ea_ff, 1'b0, he_vis[2], hp_vis[2], he_vis[1], hp_vis[1], he_vis[0], hp_vis[0]};

	// read mux; unmapped offsets answer zero
	wire [7:0] rd_mux =
		(reg_addr == `MTD_OFF_CFG) ? cfg_ff :
		(reg_addr == `MTD_OFF_SRC) ? src_byte :
		(reg_addr == `MTD_OFF_XHI) ? {dbclr_ff, thr_xh_ff} :
		(reg_addr == `MTD_OFF_XLO) ? thr_xl_ff :
		(reg_addr == `MTD_OFF_YHI) ? {1'b0, thr_yh_ff} :
		(reg_addr == `MTD_OFF_YLO) ? thr_yl_ff :
		(reg_addr == `MTD_OFF_ZHI) ? {1'b0, thr_zh_ff} :
		(reg_addr == `MTD_OFF_ZLO) ? thr_zl_ff :
		`MTD_RD_UNMAPPED;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= `MTD_RST_BYTE;
		end else if (reg_rd) begin
			rdata_ff <= rd_mux;
		end else begin
			rdata_ff <= `MTD_RST_BYTE;
		end
	end

	assign reg_rdata = rdata_ff;
	assign event_active_flag = ea_ff;

	// wake and interrupt routing from the registered flag
	wire evt_irq = ea_ff && irq_en;
	assign wake_event = ea_ff && wake_en;
	assign irq_pin_one = other_irq_one | (evt_irq & route_one);
	assign irq_pin_two = other_irq_two | (evt_irq & ~route_one);
endmodule

// [tb/mtd_top_assertions.sv]
// Purpose: port-level checks of the threshold detector
// Assumes: config byte shadowed from register writes
// Notes: one clock domain, default clocking
`timescale 1ns/1ps
module mtd_chk #(
	parameter int SW = 16
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [SW-1:0] sample_x,
	input wire logic raw_mode,
	input wire logic [SW-1:0] corr_x,
	input wire logic corr_valid,
	input wire logic event_active_flag,
	input wire logic wake_event,
	input wire logic other_irq_one,
	input wire logic other_irq_two,
	input wire logic irq_pin_one,
	input wire logic irq_pin_two
);
	logic [7:0] cfg_ff;
	wire src_rd = reg_rd && reg_addr == 8'h53;
	wire ea = event_active_flag;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// shadow of the config byte, lands with the design's copy
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) cfg_ff <= 8'h00;
		else if (reg_wr && reg_addr == 8'h52) cfg_ff <= reg_wdata;
	end
	a_pin_one_route: assert property (irq_pin_one == (other_irq_one | (ea & cfg_ff[1] & cfg_ff[0])))
		else $error("pin one routing wrong");
	a_pin_two_route: assert property (irq_pin_two == (other_irq_two | (ea & cfg_ff[1] & !cfg_ff[0])))
		else $error("pin two routing wrong");
	a_wake_gate: assert property (wake_event == (ea & cfg_ff[2]))
		else $error("wake gating wrong");
	a_raw_pass: assert property (sample_valid && raw_mode |=> corr_x == $past(sample_x))
		else $error("raw sample altered");
	a_step_pulse: assert property (sample_valid |=> corr_valid ##1 !corr_valid)
		else $error("corrected strobe wrong");
	a_rise_on_step: assert property ($rose(ea) |-> $past(corr_valid))
		else $error("flag rose off a step");
	a_track_stable: assert property (!cfg_ff[7] && !corr_valid |=> $stable(ea))
		else $error("tracking flag moved off a step");
	a_latch_hold: assert property (cfg_ff[7] && ea && !src_rd |=> ea)
		else $error("latched flag lost");
	a_read_clear: assert property (cfg_ff[7] && src_rd && !corr_valid |=> !ea)
		else $error("read did not clear flag");
	a_yz_top: assert property (reg_rd && reg_addr inside {8'h56, 8'h58} |=> !reg_rdata[7])
		else $error("unused top bit set");
	c_flag_rise: cover property ($rose(ea));
	c_read_clear: cover property (cfg_ff[7] && ea && src_rd);
	c_pin_two: cover property ($rose(irq_pin_two));
endmodule
bind mtd_top mtd_chk #(.SW(SW)) u_chk (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sample_valid(sample_valid), .sample_x(sample_x), .raw_mode(raw_mode), .corr_x(corr_x),
	.corr_valid(corr_valid), .event_active_flag(event_active_flag), .wake_event(wake_event),
	.other_irq_one(other_irq_one), .other_irq_two(other_irq_two),
	.irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));

// [tb/mtd_host.sv]
// Purpose: host model on the register port
// Assumes: no wait states, data one cycle after strobe
// Notes: strobes change only after a rising edge
`timescale 1ns/1ps
module mtd_host (
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// one-cycle write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// data stands only one cycle, so take it mid-cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask
endmodule

// [tb/tb_mtd_top.sv]
// Purpose: self-checking bench of the threshold detector
// Assumes: flags settle two edges after the sample edge
// Notes: expected bytes worked out by hand
`timescale 1ns/1ps
module tb_mtd_top;
	logic clk_sys = 1'b0, rstn = 1'b0, sample_valid = 1'b0, raw_mode = 1'b0, hybrid_mode = 1'b0;
	logic other_irq_one = 1'b0, other_irq_two = 1'b0;
	logic [15:0] sample_x = 16'h0000, sample_y = 16'h0000, sample_z = 16'h0000, corr_x;
	logic [14:0] offset_x = 15'h0000;
	logic [7:0] debounce_count = 8'h00, reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, ea, wake, irq1, irq2;
	int error_cnt = 0, compares = 0;
	mtd_host u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	mtd_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .offset_x(offset_x),
		.offset_y(15'h0000), .offset_z(15'h0000), .raw_mode(raw_mode), .hybrid_mode(hybrid_mode),
		.debounce_count(debounce_count), .other_irq_one(other_irq_one), .other_irq_two(other_irq_two),
		.corr_x(corr_x), .corr_y(), .corr_z(), .corr_valid(), .event_active_flag(ea),
		.wake_event(wake), .irq_pin_one(irq1), .irq_pin_two(irq2));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(a, d);
		chk(d, e);
	endtask
	// one sample, then wait out the two-edge flag latency
	task automatic samp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		@(posedge clk_sys);
		sample_x <= x;
		sample_y <= y;
		sample_z <= z;
		sample_valid <= 1'b1;
		@(posedge clk_sys);
		sample_valid <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic results;
		$display("compares %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic t_regs;
		for (int a = 8'h52; a <= 8'h5A; a++) rdchk(8'(a), 8'h00);
		u_host.wr(8'h54, 8'hFF);
		rdchk(8'h54, 8'hFF);
		u_host.wr(8'h56, 8'hFF);
		rdchk(8'h56, 8'h7F);
		u_host.wr(8'h58, 8'hFF);
		rdchk(8'h58, 8'h7F);
		u_host.wr(8'h53, 8'hFF);
		rdchk(8'h53, 8'h00);
		$display("test regs done");
	endtask
	// any-above mode, x threshold 100, pin one, wake on
	task automatic t_track;
		u_host.wr(8'h54, 8'h00);
		u_host.wr(8'h55, 8'h64);
		u_host.wr(8'h52, 8'h4F);
		samp(16'hFF9C, 16'h7FFF, 16'h7FFF);
		chk({ea, irq1, irq2, wake}, 4'hD);
		rdchk(8'h53, 8'h83);
		// disabling x masks its bits; tracking flag keeps until next step
		u_host.wr(8'h52, 8'h47);
		rdchk(8'h53, 8'h80);
		u_host.wr(8'h52, 8'h4F);
		samp(16'h0063, 16'h0, 16'h0);
		chk(ea, 1'b0);
		offset_x <= 15'd50;
		samp(16'd130, 16'h0, 16'h0);
		chk({corr_x, ea}, {16'd80, 1'b0});
		raw_mode <= 1'b1;
		samp(16'd130, 16'h0, 16'h0);
		chk({corr_x, ea}, {16'd130, 1'b1});
		raw_mode <= 1'b0;
		offset_x <= 15'd0;
		$display("test track done");
	endtask
	task automatic t_latch;
		u_host.wr(8'h52, 8'hCB);
		samp(16'd200, 16'h0, 16'h0);
		samp(16'd0, 16'h0, 16'h0);
		chk({ea, wake}, 2'b10);
		rdchk(8'h53, 8'h82);
		chk(ea, 1'b0);
		rdchk(8'h53, 8'h00);
		$display("test latch done");
	endtask
	// all-below mode on y and z, x out of range but disabled
	task automatic t_and;
		u_host.wr(8'h52, 8'h32);
		u_host.wr(8'h56, 8'h00);
		u_host.wr(8'h57, 8'h32);
		u_host.wr(8'h58, 8'h00);
		u_host.wr(8'h59, 8'h32);
		samp(16'h1388, 16'h0032, 16'hFFF6);
		chk({ea, irq1, irq2}, 3'b101);
		rdchk(8'h53, 8'hB8);
		samp(16'h1388, 16'h0033, 16'hFFF6);
		chk({ea, irq2}, 2'b00);
		other_irq_two <= 1'b1;
		@(negedge clk_sys);
		chk(irq2, 1'b1);
		other_irq_two <= 1'b0;
		$display("test and done");
	endtask
	// count 3: clearing mode needs three in a row, decrement mode does not
	task automatic t_deb;
		u_host.wr(8'h52, 8'h48);
		debounce_count <= 8'd3;
		for (int m = 1; m >= 0; m--) begin
			samp(16'd0, 16'h0, 16'h0);
			u_host.wr(8'h54, m ? 8'h80 : 8'h00);
			for (int i = 0; i < 5 + m; i++) begin
				samp(i == 2 ? 16'd0 : 16'd200, 16'h0, 16'h0);
				chk(ea, i == 4 + m);
			end
		end
		chk({irq1, irq2}, 2'b00);
		debounce_count <= 8'd0;
		hybrid_mode <= 1'b1;
		samp(16'd0, 16'h0, 16'h0);
		samp(16'd200, 16'h0, 16'h0);
		chk(ea, 1'b1);
		samp(16'd0, 16'h0, 16'h0);
		chk(ea, 1'b1);
		hybrid_mode <= 1'b0;
		$display("test debounce done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_regs;
		t_track;
		t_latch;
		t_and;
		t_deb;
		results;
	end
	// watchdog well past the expected run of about 820 ns
	initial begin
		#40000;
		error_cnt++;
		results;
	end
endmodule
